// >>> src/display_mem.sv
// Segment memory: one write port, one registered read port, bulk clear.
// Assumes a single clock; clear and write never needed in one cycle.
`timescale 1ns/1ps
module display_mem
   import lcd_pkg::*;
#(
   parameter int DEPTH = 15,
   parameter int WIDTH = 8,
   parameter int AW    = 4
)
(
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   // Write side
   input  wire logic             clear_i,
   input  wire logic             we_i,
   input  wire logic [AW-1:0]    waddr_i,
   input  wire logic [WIDTH-1:0] wdata_i,
   // Read side
   input  wire logic [AW-1:0]    raddr_i,
   output logic      [WIDTH-1:0] rdata_o
);

   // Refused while elaborating, before any clock runs
   if (DEPTH < 1 || DEPTH > (1 << AW))
   begin : g_bad_depth
      $error("display_mem: DEPTH does not fit AW");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];

   // Power-on and clear both leave every byte at zero
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_q[i] <= '0;
      end
      else if (clear_i)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_q[i] <= '0;
      end
      else if (we_i && int'(waddr_i) < DEPTH)
         mem_q[waddr_i] <= wdata_i;
   end

   // Out-of-range reads give zero
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         rdata_o <= '0;
      else if (int'(raddr_i) < DEPTH)
         rdata_o <= mem_q[raddr_i];
      else
         rdata_o <= '0;
   end

endmodule

// >>> src/lcd_map.svh
// Offsets, field positions, reset values and counts of the display block.
// Included by the controller source only; definitions only.
`ifndef LCD_MAP_SVH
`define LCD_MAP_SVH

// Register offsets on the SFR port
`define OFS_DISPLAY_CONFIG      8'h95
`define OFS_DISPLAY_CLOCK_CTRL  8'h96
`define OFS_DISPLAY_EXT_CONFIG  8'h9c
`define OFS_DISPLAY_POINTER     8'hac
`define OFS_DISPLAY_DATA_PORT   8'hae
`define OFS_DISPLAY_UPDATE_CTRL 8'hb1

// Reset values
`define RST_DISPLAY_CONFIG      8'h00
`define RST_DISPLAY_CLOCK_CTRL  8'h00
`define RST_DISPLAY_EXT_CONFIG  8'h00
`define RST_DISPLAY_POINTER     8'h00
`define RST_DISPLAY_DATA_PORT   8'h00
`define RST_DISPLAY_UPDATE_CTRL 8'h00

// Pointer fields
`define PTR_WRITE_BIT           7
`define PTR_ADDR_MSB            5
`define PTR_RSVD_MASK           8'hbf

// Memory geometry
`define MEM_BYTES               15
`define MEM_LAST_ADDR           6'h0e
`define SEG_LINES               29

// Frame divider code that divides by one
`define FD_DIV_ONE              4'hf

// Blink half periods in 128 Hz ticks
`define BLINK_HALF_MODE3        9'h010
`define BLINK_HALF_RATE0        9'h020
`define BLINK_HALF_RATE1        9'h040
`define BLINK_HALF_RATE2        9'h080
`define BLINK_HALF_RATE3        9'h100

`endif

// >>> src/lcd_pkg.sv
// Types shared by the display controller and its memory.
// Pairs with lcd_map.svh which holds offsets and counts.
package lcd_pkg;

   typedef struct packed {
      logic       display_enable;      // bit 7
      logic       sleep_display_off;   // bit 6
      logic       blink_enable;        // bit 5
      logic       memory_clear;        // bit 4
      logic       display_clock_source;// bit 3, 1 = 128 Hz
      logic       bias_third;          // bit 2
      logic [1:0] multiplex_select;    // bits 1:0
   } display_config_t;

   typedef struct packed {
      logic [1:0] blink_mode_field;
      logic [1:0] blink_rate_field;
      logic [3:0] frame_divider;
   } display_clock_ctrl_t;

   typedef struct packed {
      logic       drive_source_select;
      logic       reserved;
      logic [5:0] bias_level;
   } display_ext_config_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef enum logic [1:0]
   {
      OP_IDLE = 2'b01,
      OP_READ = 2'b10
   } mem_op_t;

endpackage

// >>> src/segment_lcd_controller.sv
// Segment display controller: SFR registers, indirect segment memory,
// frozen display copy, frame and blink timing, drive-source control.
// Assumes SFR strobes and display clock ticks are one-cycle pulses
// synchronous to clk_i; the analog stage builds levels from the outputs.
`timescale 1ns/1ps
`include "lcd_map.svh"
module segment_lcd_controller
   import lcd_pkg::*;
#(
   parameter int MEM_BYTES = `MEM_BYTES,
   parameter int SEG_LINES = `SEG_LINES
)
(
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 arst_n_i,
   // SFR port
   input  wire sfr_req_t             sfr_i,
   output logic      [7:0]           sfr_rdata_o,
   // Display clocks and system state
   input  wire logic                 tick_2048_i,
   input  wire logic                 tick_128_i,
   input  wire logic                 rtc_running_i,
   input  wire logic                 battery_sleep_state_i,
   // Glass drive
   output logic      [3:0]           backplane_line_o,
   output logic      [SEG_LINES-1:0] segment_line_o,
   output logic                      wave_invert_o,
   output logic      [1:0]           pin_is_backplane_o,
   output logic                      display_active_o,
   // Voltage generation
   output logic                      pump_enable_o,
   output logic                      ladder_select_o,
   output logic      [5:0]           bias_level_o
);

   // Refused while elaborating, before any clock runs
   if (MEM_BYTES != `MEM_BYTES || SEG_LINES != 2 * MEM_BYTES - 1)
   begin : g_bad_geometry
      $error("segment_lcd_controller: unsupported geometry");
   end

   // Registers
   display_config_t     cfg_q;
   display_clock_ctrl_t clk_q;
   display_ext_config_t ext_q;
   logic [7:0]          ptr_q;
   logic [7:0]          dat_q;
   logic                freeze_q;
   mem_op_t             op_q;

   // Display timing state
   logic [5:0]          div_cnt_q;
   logic [1:0]          bp_q;
   logic                inv_q;
   logic [8:0]          blink_cnt_q;
   logic                blink_on_q;
   logic [7:0]          shadow_q [MEM_BYTES];
   logic [3:0]          scan_q;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   function automatic logic [5:0] frame_period(input logic [3:0] fd);
      if (fd == `FD_DIV_ONE)
         frame_period = 6'h01;
      else
         frame_period = {1'b0, fd, 1'b0} + 6'h02;
   endfunction

   function automatic logic [8:0] blink_half(input logic [1:0] m,
                                             input logic [1:0] r);
      if (m == 2'h3)
         blink_half = `BLINK_HALF_MODE3;
      else
      begin
         case (r)
            2'h0:    blink_half = `BLINK_HALF_RATE0;
            2'h1:    blink_half = `BLINK_HALF_RATE1;
            2'h2:    blink_half = `BLINK_HALF_RATE2;
            default: blink_half = `BLINK_HALF_RATE3;
         endcase
      end
   endfunction

   // SFR decode
   wire logic wr_cfg  = sfr_i.wr && hit(sfr_i.addr, `OFS_DISPLAY_CONFIG);
   wire logic wr_clk  = sfr_i.wr && hit(sfr_i.addr, `OFS_DISPLAY_CLOCK_CTRL);
   wire logic wr_ext  = sfr_i.wr && hit(sfr_i.addr, `OFS_DISPLAY_EXT_CONFIG);
   wire logic wr_ptr  = sfr_i.wr && hit(sfr_i.addr, `OFS_DISPLAY_POINTER);
   wire logic wr_dat  = sfr_i.wr && hit(sfr_i.addr, `OFS_DISPLAY_DATA_PORT);
   wire logic wr_upd  = sfr_i.wr && hit(sfr_i.addr, `OFS_DISPLAY_UPDATE_CTRL);

   wire logic [5:0] ptr_addr = sfr_i.wdata[`PTR_ADDR_MSB:0];
   wire logic       ptr_in_range = ptr_addr <= `MEM_LAST_ADDR;
   wire logic       mem_we  = wr_ptr && sfr_i.wdata[`PTR_WRITE_BIT]
                              && ptr_in_range;
   wire logic       ptr_rd  = wr_ptr && !sfr_i.wdata[`PTR_WRITE_BIT];
   wire logic       mem_clr = wr_cfg && sfr_i.wdata[4];

   // One read port: pointer reads win, otherwise the display scan runs
   wire logic [3:0] mem_raddr = ptr_rd ? (ptr_in_range ? ptr_addr[3:0]
                                                       : 4'hf)
                                       : scan_q;
   wire logic [7:0] mem_rdata;

   display_mem #(
      .DEPTH (MEM_BYTES),
      .WIDTH (8),
      .AW    (4)
   ) u_mem (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .clear_i  (mem_clr),
      .we_i     (mem_we),
      .waddr_i  (ptr_addr[3:0]),
      .wdata_i  (dat_q),
      .raddr_i  (mem_raddr),
      .rdata_o  (mem_rdata)
   );

   // Register writes
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cfg_q    <= `RST_DISPLAY_CONFIG;
         clk_q    <= `RST_DISPLAY_CLOCK_CTRL;
         ext_q    <= `RST_DISPLAY_EXT_CONFIG;
         ptr_q    <= `RST_DISPLAY_POINTER;
         freeze_q <= 1'b0;
      end
      else
      begin
         if (wr_cfg)
            cfg_q <= sfr_i.wdata & 8'hef; // clear bit is one-shot
         if (wr_clk)
            clk_q <= sfr_i.wdata;
         if (wr_ext)
            ext_q <= sfr_i.wdata;
         if (wr_ptr)
            ptr_q <= sfr_i.wdata & `PTR_RSVD_MASK;
         if (wr_upd)
            freeze_q <= sfr_i.wdata[0];
      end
   end

   // Data register: firmware write or a pointer read one cycle later
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         dat_q <= `RST_DISPLAY_DATA_PORT;
         op_q  <= OP_IDLE;
      end
      else
      begin
         case (op_q)
            OP_IDLE:
            begin
               if (ptr_rd)
                  op_q <= OP_READ;
               if (wr_dat)
                  dat_q <= sfr_i.wdata;
            end
            OP_READ:
            begin
               dat_q <= mem_rdata;
               op_q  <= ptr_rd ? OP_READ : OP_IDLE;
            end
            default:
               op_q <= OP_IDLE;
         endcase
      end
   end

   // Read data
   logic [7:0] rd_mux;
   always_comb
   begin
      rd_mux = 8'h00;
      if (hit(sfr_i.addr, `OFS_DISPLAY_CONFIG))
         rd_mux = cfg_q;
      else if (hit(sfr_i.addr, `OFS_DISPLAY_CLOCK_CTRL))
         rd_mux = clk_q;
      else if (hit(sfr_i.addr, `OFS_DISPLAY_EXT_CONFIG))
         rd_mux = {ext_q.drive_source_select, 1'b0, ext_q.bias_level};
      else if (hit(sfr_i.addr, `OFS_DISPLAY_POINTER))
         rd_mux = ptr_q;
      else if (hit(sfr_i.addr, `OFS_DISPLAY_DATA_PORT))
         rd_mux = dat_q;
      else if (hit(sfr_i.addr, `OFS_DISPLAY_UPDATE_CTRL))
         rd_mux = {7'h00, freeze_q};
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         sfr_rdata_o <= 8'h00;
      else if (sfr_i.rd)
         sfr_rdata_o <= rd_mux;
   end

   // Display copy refreshed by scan only while not frozen
   wire logic       scan_used = !ptr_rd;
   logic      [3:0] scan_prev_q;
   logic            scan_valid_q;

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         scan_q       <= 4'h0;
         scan_prev_q  <= 4'h0;
         scan_valid_q <= 1'b0;
         for (int i = 0; i < MEM_BYTES; i++)
            shadow_q[i] <= 8'h00;
      end
      else
      begin
         scan_valid_q <= scan_used;
         scan_prev_q  <= scan_q;
         if (scan_used)
            scan_q <= (int'(scan_q) == MEM_BYTES - 1) ? 4'h0
                                                       : scan_q + 4'h1;
         if (scan_valid_q && !freeze_q)
            shadow_q[scan_prev_q] <= mem_rdata;
      end
   end

   // Frame timing
   wire logic       tick = cfg_q.display_clock_source ? tick_128_i
                                                      : tick_2048_i;
   wire logic [5:0] period = frame_period(clk_q.frame_divider);
   wire logic [1:0] bp_last = (cfg_q.multiplex_select < 2'h2) ? 2'h1
                                 : cfg_q.multiplex_select;
   wire logic       div_done = tick && (div_cnt_q + 6'h01 >= period);

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         div_cnt_q <= 6'h00;
         inv_q     <= 1'b0;
         bp_q      <= 2'h0;
      end
      else
      begin
         if (div_done)
            div_cnt_q <= 6'h00;
         else if (tick)
            div_cnt_q <= div_cnt_q + 6'h01;
         if (div_done)
            inv_q <= !inv_q;
         if (div_done && inv_q)
            bp_q <= (bp_q >= bp_last) ? 2'h0 : bp_q + 2'h1;
      end
   end

   // Blink timing
   wire logic       auto_blink = clk_q.blink_mode_field[1];
   wire logic [8:0] half = blink_half(clk_q.blink_mode_field,
                                      clk_q.blink_rate_field);
   wire logic       blink_step = auto_blink && rtc_running_i && tick_128_i;
   wire logic       blink_wrap = blink_step && (blink_cnt_q + 9'h001 >= half);

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         blink_cnt_q <= 9'h000;
         blink_on_q  <= 1'b1;
      end
      else if (!auto_blink)
      begin
         blink_cnt_q <= 9'h000;
         blink_on_q  <= clk_q.blink_mode_field[0];
      end
      else if (blink_wrap)
      begin
         blink_cnt_q <= 9'h000;
         blink_on_q  <= !blink_on_q;
      end
      else if (blink_step)
         blink_cnt_q <= blink_cnt_q + 9'h001;
   end

   // Display gating
   wire logic sleep_ok = !battery_sleep_state_i
                         || !cfg_q.sleep_display_off;
   wire logic enabled  = cfg_q.display_enable && sleep_ok;
   wire logic showing  = enabled
                         && (!cfg_q.blink_enable || blink_on_q);
   wire logic pin28_bp = cfg_q.multiplex_select >= 2'h2;
   wire logic pin27_bp = cfg_q.multiplex_select == 2'h3;

   // Segment selection per line
   logic [SEG_LINES-1:0] seg_d;
   genvar s;
   generate
      for (s = 0; s < SEG_LINES; s++)
      begin : g_seg
         wire logic shared_bp = (s == 28) ? pin28_bp
                               : (s == 27) ? pin27_bp : 1'b0;
         assign seg_d[s] = showing && !shared_bp
                           && shadow_q[s / 2][(s % 2) * 4
                                              + int'(bp_q)];
      end
   endgenerate

   // Output flops
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         backplane_line_o   <= 4'h0;
         segment_line_o     <= '0;
         wave_invert_o      <= 1'b0;
         pin_is_backplane_o <= 2'h0;
         display_active_o   <= 1'b0;
         pump_enable_o      <= 1'b0;
         ladder_select_o    <= 1'b0;
         bias_level_o       <= 6'h00;
      end
      else
      begin
         backplane_line_o   <= showing ? (4'h1 << bp_q) : 4'h0;
         segment_line_o     <= seg_d;
         wave_invert_o      <= showing && inv_q;
         pin_is_backplane_o <= {pin27_bp, pin28_bp};
         display_active_o   <= showing;
         pump_enable_o      <= enabled
                               && !ext_q.drive_source_select;
         ladder_select_o    <= ext_q.drive_source_select;
         bias_level_o       <= ext_q.drive_source_select ? 6'h00
                               : ext_q.bias_level;
      end
   end

endmodule

// >>> verification/lcd_glass_model.sv
// Glass panel: keeps the segment pattern seen on each backplane.
// Passive; assumes the controller's outputs are registered.
`timescale 1ns/1ps
module lcd_glass_model
#(
   parameter int SEG_LINES = 29
)
(
   input  wire logic                 clk_i,
   input  wire logic [3:0]           backplane_line_i,
   input  wire logic [SEG_LINES-1:0] segment_line_i,
   input  wire logic                 wave_invert_i,
   input  wire logic                 display_active_i,
   output logic [3:0][SEG_LINES-1:0] seen_o,
   output int unsigned               flips_o
);
   logic inv_q = 1'b0;
   initial seen_o = '0;
   initial flips_o = 0;
   always @(posedge clk_i)
   begin
      inv_q <= wave_invert_i;
      if (display_active_i)
      begin
         for (int k = 0; k < 4; k++)
            if (backplane_line_i[k])
               seen_o[k] <= segment_line_i;
         if (wave_invert_i != inv_q)
            flips_o <= flips_o + 1;
      end
   end
endmodule

// >>> verification/segment_lcd_controller_chk.sv
// Port-level checks of the segment display controller.
// Bound to the controller; sees only its ports, one clock domain.
`timescale 1ns/1ps
module segment_lcd_controller_chk
   import lcd_pkg::*;
#(
   parameter int SEG_LINES = 29
)
(
   // Clock and reset
   input wire logic                 clk_i,
   input wire logic                 arst_n_i,
   // SFR port
   input wire sfr_req_t             sfr_i,
   input wire logic [7:0]           sfr_rdata_o,
   // Glass and voltage side
   input wire logic [3:0]           backplane_line_o,
   input wire logic                 wave_invert_o,
   input wire logic [1:0]           pin_is_backplane_o,
   input wire logic                 display_active_o,
   input wire logic                 pump_enable_o,
   input wire logic                 ladder_select_o,
   input wire logic [5:0]           bias_level_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   wire logic wr_cfg = sfr_i.wr && sfr_i.addr == 8'h95;
   wire logic wr_ext = sfr_i.wr && sfr_i.addr == 8'h9c;
   wire logic ptr_far = sfr_i.wr && sfr_i.addr == 8'hac
      && !sfr_i.wdata[7] && sfr_i.wdata[5:0] > 6'h0e;

   rdata_hold_a: assert property (!sfr_i.rd |=> $stable(sfr_rdata_o))
      else $error("read data moved without a read");
   far_read_zero_a: assert property (ptr_far ##2 (sfr_i.rd &&
      sfr_i.addr == 8'hae) |=> sfr_rdata_o == 8'h00)
      else $error("read of address above 14 not zero");
   ptr_rsvd_a: assert property (sfr_i.rd && sfr_i.addr == 8'hac
      |=> !sfr_rdata_o[6]) else $error("pointer bit 6 reads one");
   pump_ladder_a: assert property (pump_enable_o |-> !ladder_select_o)
      else $error("pump on with ladder selected");
   ladder_bias_a: assert property (ladder_select_o |-> bias_level_o == 0)
      else $error("bias level driven in ladder mode");
   bp_onehot_a: assert property ($onehot0(backplane_line_o))
      else $error("more than one backplane active");
   pin_order_a: assert property (pin_is_backplane_o != 2'b10)
      else $error("pin 27 backplane without pin 28");
   dark_quiet_a: assert property (!display_active_o [*2] |->
      backplane_line_o == 4'h0 && !wave_invert_o)
      else $error("glass driven while display off");
   pump_off_a: assert property (wr_cfg && !sfr_i.wdata[7] ##1 !wr_cfg
      |=> !pump_enable_o) else $error("pump on after display off");
   ladder_set_a: assert property (wr_ext ##1 !wr_ext |=>
      ladder_select_o == $past(sfr_i.wdata[7], 2))
      else $error("ladder select not following write");

   ptr_wr_c: cover property (sfr_i.wr && sfr_i.addr == 8'hac);
   active_c: cover property ($rose(display_active_o));
   invert_c: cover property ($rose(wave_invert_o));
   pump_c: cover property ($rose(pump_enable_o));
endmodule

// >>> verification/segment_lcd_controller_tb.sv
// Self-checking bench of the segment display controller.
// Drives SFR cycles and display ticks, watches the glass model.
`timescale 1ns/1ps
module segment_lcd_controller_tb
   import lcd_pkg::*;
;
   logic clk_i = 1'b0, arst_n_i = 1'b0, rtc_i = 1'b0, sleep_i = 1'b0;
   logic t2k = 1'b0, t128 = 1'b0;
   sfr_req_t sfr = '0;
   logic [7:0] rdata, rd_q, old;
   logic [3:0] bp;
   logic [28:0] seg, olds;
   logic inv, act, pump, lad;
   logic [1:0] pins;
   logic [5:0] bias;
   logic [3:0][28:0] seen;
   int unsigned flips, f0;
   logic [7:0] mem [15];
   logic [7:0] ofs [6] = '{8'h95, 8'h96, 8'h9c, 8'hac, 8'hae, 8'hb1};
   logic [7:0] msk [6] = '{8'hef, 8'hff, 8'hbf, 8'hbf, 8'hff, 8'h01};
   int n_fail = 0, checked = 0, tcnt = 0, cnt;

   segment_lcd_controller segment_lcd_controller_inst (.clk_i(clk_i),
      .arst_n_i(arst_n_i), .sfr_i(sfr), .sfr_rdata_o(rdata),
      .tick_2048_i(t2k), .tick_128_i(t128), .rtc_running_i(rtc_i),
      .battery_sleep_state_i(sleep_i), .backplane_line_o(bp),
      .segment_line_o(seg), .wave_invert_o(inv), .pin_is_backplane_o(pins),
      .display_active_o(act), .pump_enable_o(pump),
      .ladder_select_o(lad), .bias_level_o(bias));
   lcd_glass_model lcd_glass_model_inst (.clk_i(clk_i),
      .backplane_line_i(bp), .segment_line_i(seg), .wave_invert_i(inv),
      .display_active_i(act), .seen_o(seen), .flips_o(flips));

   always #2 clk_i = ~clk_i;
   // Tick ratio 16 keeps blink runs short
   always @(posedge clk_i)
   begin
      tcnt <= tcnt + 1;
      t2k <= #1 (tcnt % 2 == 0);
      t128 <= #1 (tcnt % 32 == 0);
   end

   task automatic conclude();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cmp8(string nm, logic [7:0] e, logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         $display("MISMATCH %s exp %h got %h", nm, e, g);
         n_fail++;
      end
   endtask
   task automatic cmp_seg(logic [28:0] e, logic [28:0] g);
      checked++;
      if (g !== e)
      begin
         $display("MISMATCH segments exp %h got %h", e, g);
         n_fail++;
      end
   endtask
   task automatic sfr_op(logic w, logic [7:0] a, logic [7:0] d);
      @(posedge clk_i);
      #1;
      sfr = '{addr: a, wr: w, rd: !w, wdata: d};
      @(posedge clk_i);
      #1;
      rd_q = rdata;
      sfr.wr = 1'b0;
      sfr.rd = 1'b0;
   endtask
   task automatic mem_wr(logic [5:0] n, logic [7:0] d);
      sfr_op(1'b1, 8'hae, d);
      sfr_op(1'b1, 8'hac, {2'b10, n});
      if (n < 15)
         mem[n] = d;
   endtask
   task automatic mem_check();
      for (int n = 0; n < 17; n++)
      begin
         sfr_op(1'b1, 8'hac, (n == 16) ? 8'h3f : 8'(n));
         sfr_op(1'b0, 8'hae, 8'h00);
         cmp8("memory", (n < 15) ? mem[n] : 8'h00, rd_q);
      end
   endtask
   task automatic wait_act(logic v);
      for (cnt = 0; cnt < 400 && act !== v; cnt++)
         @(posedge clk_i);
      #1;
      if (act !== v)
      begin
         n_fail++;
         conclude();
      end
   endtask
   function automatic logic [28:0] exp_seg(int k);
      for (int s = 0; s < 29; s++)
         exp_seg[s] = mem[s / 2][(s % 2) * 4 + k];
      // Bench runs 4x multiplexing: both shared pins are backplanes
      exp_seg[28:27] = 2'b00;
   endfunction

   initial
   begin
      repeat (90000) @(posedge clk_i);
      n_fail++;
      conclude();
   end

   initial
   begin
      void'($urandom(32));
      repeat (3) @(posedge clk_i);
      #1 arst_n_i = 1'b1;
      foreach (ofs[i])
      begin
         sfr_op(1'b0, ofs[i], 8'h00);
         cmp8("reset", 8'h00, rd_q);
      end
      foreach (ofs[i])
      begin
         old = $urandom;
         sfr_op(1'b1, ofs[i], old);
         sfr_op(1'b0, ofs[i], 8'h00);
         cmp8("register", old & msk[i], rd_q);
      end
      sfr_op(1'b1, 8'h90, 8'h5a);
      sfr_op(1'b0, 8'h90, 8'h00);
      cmp8("unmapped", 8'h00, rd_q);
      sfr_op(1'b1, 8'hb1, 8'h00);
      sfr_op(1'b1, 8'h95, 8'h10);
      foreach (mem[n])
         mem[n] = 8'h00;
      mem_check();
      foreach (mem[n])
         mem_wr(6'(n), 8'($urandom));
      mem_wr(6'(15 + $urandom % 49), 8'($urandom));
      mem_check();
      sfr_op(1'b1, 8'h9c, 8'h15);
      sfr_op(1'b1, 8'h96, 8'h0f);
      sfr_op(1'b1, 8'h95, 8'h83);
      wait_act(1'b1);
      repeat (100) @(posedge clk_i);
      for (int k = 0; k < 4; k++)
         cmp_seg(exp_seg(k), seen[k]);
      cmp8("pump", 8'h01, 8'(pump));
      cmp8("bias", 8'h15, 8'(bias));
      // One inversion per frame period of ticks; last pass on 128 Hz
      foreach (ofs[i])
      begin
         old = (i == 1) ? 8'h00 : (i == 2) ? 8'h01 : 8'h0f;
         sfr_op(1'b1, 8'h95, (i == 5) ? 8'h8b : 8'h83);
         sfr_op(1'b1, 8'h96, old);
         repeat (20) @(posedge clk_i);
         f0 = flips;
         repeat (64) @(posedge clk_i);
         cnt = ((i == 5) ? 2 : 32) / ((old == 8'h0f) ? 1 : 2 * (old + 1));
         cmp8("flips", 8'h01, 8'((flips - f0) inside {[cnt-1:cnt+1]}));
      end
      sfr_op(1'b1, 8'h95, 8'h83);
      sfr_op(1'b1, 8'h96, 8'h0f);
      olds = exp_seg(0);
      sfr_op(1'b1, 8'hb1, 8'h01);
      mem_wr(6'h00, ~mem[0]);
      repeat (100) @(posedge clk_i);
      cmp_seg(olds, seen[0]);
      sfr_op(1'b1, 8'hb1, 8'h00);
      repeat (100) @(posedge clk_i);
      cmp_seg(exp_seg(0), seen[0]);
      sfr_op(1'b1, 8'h9c, 8'h95);
      repeat (3) @(posedge clk_i);
      cmp8("ladder", 8'h80, {lad, pump, bias});
      sfr_op(1'b1, 8'h9c, 8'h15);
      for (int m = 0; m < 4; m++)
      begin
         sfr_op(1'b1, 8'h95, 8'(8'h80 | m));
         repeat (3) @(posedge clk_i);
         cmp8("pins", 8'(m == 3 ? 3 : m == 2 ? 1 : 0), 8'(pins));
      end
      sleep_i = 1'b1;
      sfr_op(1'b1, 8'h95, 8'hc3);
      wait_act(1'b0);
      cmp8("sleep pump", 8'h00, 8'(pump));
      sfr_op(1'b1, 8'h95, 8'h83);
      wait_act(1'b1);
      sleep_i = 1'b0;
      sfr_op(1'b1, 8'h95, 8'h03);
      wait_act(1'b0);
      mem_check();
      sfr_op(1'b1, 8'h95, 8'ha3);
      sfr_op(1'b1, 8'h96, 8'h0f);
      wait_act(1'b0);
      sfr_op(1'b1, 8'h96, 8'h4f);
      wait_act(1'b1);
      rtc_i = 1'b1;
      for (int b = 0; b < 2; b++)
      begin
         sfr_op(1'b1, 8'h96, b ? 8'h8f : 8'hcf);
         cnt = 0;
         old = 8'(act);
         repeat (2048)
         begin
            @(posedge clk_i);
            #1;
            cnt += (act !== old[0]);
            old = 8'(act);
         end
         cmp8("blinks", 8'h01, 8'(cnt inside {[3-2*b:5-2*b]}));
      end
      conclude();
   end
endmodule

bind segment_lcd_controller segment_lcd_controller_chk
   #(.SEG_LINES(SEG_LINES)) chk_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .sfr_i(sfr_i), .sfr_rdata_o(sfr_rdata_o),
   .backplane_line_o(backplane_line_o), .wave_invert_o(wave_invert_o),
   .pin_is_backplane_o(pin_is_backplane_o),
   .display_active_o(display_active_o), .pump_enable_o(pump_enable_o),
   .ladder_select_o(ladder_select_o), .bias_level_o(bias_level_o));
